// [logic/lpic_pwm_ctrl.sv]
// PWM, converter-mode and sink-balance control register of the LED flash driver.
// Assumes the two-wire slave decodes accesses into a one-cycle write strobe with
// address and data on clk_i; comparator and converter-run levels come from analog.
// Functional notes
// - Indicator mode PWM at 31.5kHz, duty 1..4/16
// - PWM only when control mode equals 00
// - Frequency switch cleared: pulse-skip always allowed
// - Switch set, flash/assist, currents>=40h, no boost: fixed
// - Indicator or low-current mode always pulse-skips
// - Sink flags update only while converter runs; read-only
// - Bit 3 set when sink A exceeds B
// - Bit 4 set when sink B exceeds A
// - Balance bit trims sink currents within ten percent
// - Current boost input blocks fixed-frequency operation
`timescale 1ns/1ps
`include "lpic_defines.svh"

module lpic_pwm_ctrl
   import lpic_pkg::*;
(
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_n_i,
   // Register access from the two-wire slave
   input wire logic reg_wr_i,
   input wire logic [7:0] reg_addr_i,
   input wire logic [7:0] reg_wdata_i,
   output logic [7:0] reg_rdata_o,
   // Device context from other registers
   input wire logic [1:0] mode_setting_i,
   input wire logic [7:0] sink_a_current_setting_i,
   input wire logic [7:0] sink_b_current_setting_i,
   input wire logic current_boost_i,
   // Analog inputs, asynchronous
   input wire logic converter_on_i,
   input wire logic sink_a_above_cmp_i,
   input wire logic sink_b_above_cmp_i,
   // Controls toward the converter and sinks
   output logic sink_drive_o,
   output logic pulse_skip_en_o,
   output logic fixed_freq_o,
   output logic load_balance_en_o,
   output logic [7:0] sink_a_current_adj_o,
   output logic [7:0] sink_b_current_adj_o
);

   localparam logic [6:0] SLOT_LAST = 7'(`LPIC_SLOT_CYC - 1);

   // Register fields
   logic [1:0] duty_reg, duty_next;
   logic fsw_reg, fsw_next;
   logic bal_reg, bal_next;
   logic sink_a_higher_flag_reg, sink_a_higher_flag_next;
   logic sink_b_higher_flag_reg, sink_b_higher_flag_next;
   // Synchronisers: stage 1 feeds stage 2 only
   logic [2:0] sync1_reg, sync1_next;
   logic [2:0] sync2_reg, sync2_next;
   // PWM timing
   logic [6:0] slot_cnt_reg, slot_cnt_next;
   logic [3:0] slot_reg, slot_next;
   logic drive_reg, drive_next;
   // Converter and balance outputs
   logic fixed_reg, fixed_next;
   lpic_byte_t a_adj_reg, a_adj_next;
   lpic_byte_t b_adj_reg, b_adj_next;
   logic [15:0] a_trim, b_trim;
   logic [8:0] a_up, b_up;
   logic wr_hit;
   logic pwm_mode;

   assign wr_hit = reg_wr_i && (reg_addr_i == `LPIC_PWM_BAL_ADDR);
   assign pwm_mode = (mode_setting_i == `LPIC_MODE_INDICATOR);
   assign a_trim = 16'(sink_a_current_setting_i * `LPIC_TRIM_NUM);
   assign b_trim = 16'(sink_b_current_setting_i * `LPIC_TRIM_NUM);
   assign a_up = {1'b0, sink_a_current_setting_i} + {1'b0, a_trim[15:8]};
   assign b_up = {1'b0, sink_b_current_setting_i} + {1'b0, b_trim[15:8]};

   // Next state of every register group
   always_comb
   begin
      duty_next = duty_reg;
      fsw_next = fsw_reg;
      bal_next = bal_reg;
      if (wr_hit)
      begin
         // Flag bits and bits 7:6 are not stored, so writes to them vanish
         duty_next = reg_wdata_i[`LPIC_DUTY_MSB:`LPIC_DUTY_LSB];
         fsw_next = reg_wdata_i[`LPIC_FSW_BIT];
         bal_next = reg_wdata_i[`LPIC_BAL_BIT];
      end
      sync1_next = {converter_on_i, sink_b_above_cmp_i, sink_a_above_cmp_i};
      sync2_next = sync1_reg;
      // Flags freeze while the converter is off, keeping the last valid result
      sink_a_higher_flag_next = sync2_reg[2] ? sync2_reg[0] : sink_a_higher_flag_reg;
      sink_b_higher_flag_next = sync2_reg[2] ? sync2_reg[1] : sink_b_higher_flag_reg;
      // Slot divider: 16 slots form one PWM period
      if (slot_cnt_reg == SLOT_LAST)
      begin
         slot_cnt_next = 7'h00;
         slot_next = slot_reg + 4'h1;
      end
      else
      begin
         slot_cnt_next = slot_cnt_reg + 7'h01;
         slot_next = slot_reg;
      end
      // Duty code n drives the sinks for n+1 of 16 slots
      drive_next = pwm_mode ? (slot_next <= {2'h0, duty_reg}) : 1'b1;
      // Boost raises currents past the table, so fixed frequency is refused
      fixed_next = fsw_reg && !pwm_mode && !current_boost_i
         && ((mode_setting_i == `LPIC_MODE_FLASH) || (mode_setting_i == `LPIC_MODE_ASSIST))
         && (sink_a_current_setting_i >= `LPIC_FIXED_MIN_CURRENT)
         && (sink_b_current_setting_i >= `LPIC_FIXED_MIN_CURRENT);
      // Sink with more headroom takes more current, the other less
      a_adj_next = sink_a_current_setting_i;
      b_adj_next = sink_b_current_setting_i;
      if (bal_reg && sink_a_higher_flag_reg)
      begin
         a_adj_next = a_up[8] ? 8'hFF : a_up[7:0];
         b_adj_next = sink_b_current_setting_i - b_trim[15:8];
      end
      else if (bal_reg && sink_b_higher_flag_reg)
      begin
         a_adj_next = sink_a_current_setting_i - a_trim[15:8];
         b_adj_next = b_up[8] ? 8'hFF : b_up[7:0];
      end
   end

   // Registers, all cleared by the synchronous reset
   always_ff @(posedge clk_i)
   begin
      if (!rst_n_i)
      begin
         duty_reg <= 2'h0;
         fsw_reg <= 1'b0;
         bal_reg <= 1'b0;
         sink_a_higher_flag_reg <= 1'b0;
         sink_b_higher_flag_reg <= 1'b0;
         sync1_reg <= 3'h0;
         sync2_reg <= 3'h0;
         slot_cnt_reg <= 7'h00;
         slot_reg <= 4'h0;
         drive_reg <= 1'b0;
         fixed_reg <= 1'b0;
         a_adj_reg <= 8'h00;
         b_adj_reg <= 8'h00;
      end
      else
      begin
         duty_reg <= duty_next;
         fsw_reg <= fsw_next;
         bal_reg <= bal_next;
         sink_a_higher_flag_reg <= sink_a_higher_flag_next;
         sink_b_higher_flag_reg <= sink_b_higher_flag_next;
         sync1_reg <= sync1_next;
         sync2_reg <= sync2_next;
         slot_cnt_reg <= slot_cnt_next;
         slot_reg <= slot_next;
         drive_reg <= drive_next;
         fixed_reg <= fixed_next;
         a_adj_reg <= a_adj_next;
         b_adj_reg <= b_adj_next;
      end
   end

   // Read data is combinational from the stored fields; other addresses read zero
   always_comb
   begin
      reg_rdata_o = 8'h00;
      if (reg_addr_i == `LPIC_PWM_BAL_ADDR)
      begin
         reg_rdata_o = {2'h0, bal_reg, sink_b_higher_flag_reg,
            sink_a_higher_flag_reg, fsw_reg, duty_reg};
      end
   end

   assign sink_drive_o = drive_reg;
   assign fixed_freq_o = fixed_reg;
   assign pulse_skip_en_o = !fixed_reg;
   assign load_balance_en_o = bal_reg;
   assign sink_a_current_adj_o = a_adj_reg;
   assign sink_b_current_adj_o = b_adj_reg;

   // Checks
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);

   AST_PWM_DUTY: assert property (pwm_mode && $stable(duty_reg) && $stable(mode_setting_i)
      |=> sink_drive_o == (slot_reg <= {2'h0, $past(duty_reg)}))
      else $error("PWM drive does not follow duty code");
   AST_NO_PWM_OTHER: assert property (!pwm_mode |=> sink_drive_o)
      else $error("Sink drive gated outside indicator mode");
   AST_FSW_OFF_SKIP: assert property (!fsw_reg |=> pulse_skip_en_o)
      else $error("Pulse skip blocked with switch cleared");
   AST_FIXED_COND: assert property (fsw_reg && !current_boost_i
      && (mode_setting_i == `LPIC_MODE_FLASH)
      && (sink_a_current_setting_i >= `LPIC_FIXED_MIN_CURRENT)
      && (sink_b_current_setting_i >= `LPIC_FIXED_MIN_CURRENT) |=> fixed_freq_o)
      else $error("Fixed frequency not entered");
   AST_PWM_SKIP: assert property (pwm_mode |=> pulse_skip_en_o)
      else $error("Pulse skip disabled in indicator mode");
   AST_FLAG_HOLD: assert property (!sync2_reg[2] |=> $stable(sink_a_higher_flag_reg)
      && $stable(sink_b_higher_flag_reg))
      else $error("Flag changed while converter off");
   AST_FLAG_A: assert property (sync2_reg[2] |=> sink_a_higher_flag_reg == $past(sync2_reg[0]))
      else $error("Sink A flag wrong");
   AST_FLAG_B: assert property (sync2_reg[2] |=> sink_b_higher_flag_reg == $past(sync2_reg[1]))
      else $error("Sink B flag wrong");
   AST_BAL_OFF: assert property (!bal_reg |=> sink_a_current_adj_o == $past(sink_a_current_setting_i))
      else $error("Trim applied with balance off");
   AST_BOOST_BLOCK: assert property (current_boost_i |=> !fixed_freq_o)
      else $error("Fixed frequency with boost set");
   // Either sink below the threshold must leave pulse skip available
   AST_FIXED_NEED: assert property ((sink_a_current_setting_i < `LPIC_FIXED_MIN_CURRENT)
      || (sink_b_current_setting_i < `LPIC_FIXED_MIN_CURRENT) |=> !fixed_freq_o)
      else $error("Fixed frequency with low sink current");
   // Trim stays inside the ten percent band in both directions
   AST_BAL_A_UP: assert property (bal_reg && sink_a_higher_flag_reg
      |=> (sink_a_current_adj_o >= $past(sink_a_current_setting_i))
      && (10 * sink_a_current_adj_o <= 11 * $past(sink_a_current_setting_i)))
      else $error("Sink A balance trim out of band");
   AST_BAL_B_DOWN: assert property (bal_reg && sink_a_higher_flag_reg
      |=> (sink_b_current_adj_o <= $past(sink_b_current_setting_i))
      && (10 * sink_b_current_adj_o >= 9 * $past(sink_b_current_setting_i)))
      else $error("Sink B balance trim out of band");
   AST_RDATA_TOP: assert property ((reg_addr_i == `LPIC_PWM_BAL_ADDR) |-> reg_rdata_o[7:6] == 2'h0)
      else $error("Unused bits read non-zero");

endmodule

// [logic/lpic_defines.svh]
// Constants for the PWM and balance control register of the LED flash driver.
// Assumes a 40 MHz core clock and 8-bit register addresses and data.
`ifndef LPIC_DEFINES_SVH
`define LPIC_DEFINES_SVH

// Register offset and reset value
`define LPIC_PWM_BAL_ADDR 8'h09
`define LPIC_PWM_BAL_RESET 8'h00

// Field positions
`define LPIC_DUTY_LSB 0
`define LPIC_DUTY_MSB 1
`define LPIC_FSW_BIT 2
`define LPIC_A_HIGH_BIT 3
`define LPIC_B_HIGH_BIT 4
`define LPIC_BAL_BIT 5

// Operating mode codes of the control register field
`define LPIC_MODE_INDICATOR 2'h0
`define LPIC_MODE_ASSIST 2'h2
`define LPIC_MODE_FLASH 2'h3

// Current threshold for fixed-frequency operation
`define LPIC_FIXED_MIN_CURRENT 8'h40

// Timing: PWM rate and its slot length in clock cycles (16 slots per period)
`define LPIC_CLK_HZ 40000000
`define LPIC_PWM_HZ 31500
`define LPIC_PWM_SLOTS 16
`define LPIC_SLOT_CYC ((`LPIC_CLK_HZ + (`LPIC_PWM_HZ * `LPIC_PWM_SLOTS) / 2) / (`LPIC_PWM_HZ * `LPIC_PWM_SLOTS))

// Balance trim: 25/256 of the setting, just under ten percent
`define LPIC_TRIM_NUM 8'h19

`endif

// [logic/lpic_pkg.sv]
// Types shared by the PWM and balance control logic.
// Assumes lpic_defines.svh is included by the design files.
package lpic_pkg;
   typedef logic [1:0] lpic_mode_t;
   typedef logic [7:0] lpic_byte_t;
endpackage

// [testbench/lpic_pwm_ctrl_test.sv]
// Self-checking bench for the PWM and balance control register.
// Assumes the 40 MHz core clock and the write-strobe register port.
`timescale 1ns/1ps
`include "lpic_defines.svh"
module lpic_pwm_ctrl_test
   import lpic_pkg::*;
;
   logic clk_i = 0, rst_n_i = 0, reg_wr_i = 0, current_boost_i = 0;
   logic converter_on_i = 0, sink_a_above_cmp_i = 0, sink_b_above_cmp_i = 0;
   logic [7:0] reg_addr_i = 8'h09, reg_wdata_i = 8'h00, reg_rdata_o;
   logic [7:0] sink_a_current_setting_i = 8'h00, sink_b_current_setting_i = 8'h00;
   lpic_mode_t mode_setting_i = 2'h0;
   logic sink_drive_o, pulse_skip_en_o, fixed_freq_o, load_balance_en_o;
   logic [7:0] sink_a_current_adj_o, sink_b_current_adj_o;
   logic clr = 0;
   logic [19:0] q[$];
   logic [15:0] hi_count = 16'h0000;
   int bad_count = 0, tests_run = 0, cycles = 0;
   lpic_pwm_ctrl u_dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .reg_wr_i(reg_wr_i),
      .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
      .mode_setting_i(mode_setting_i), .sink_a_current_setting_i(sink_a_current_setting_i),
      .sink_b_current_setting_i(sink_b_current_setting_i), .current_boost_i(current_boost_i),
      .converter_on_i(converter_on_i), .sink_a_above_cmp_i(sink_a_above_cmp_i),
      .sink_b_above_cmp_i(sink_b_above_cmp_i), .sink_drive_o(sink_drive_o),
      .pulse_skip_en_o(pulse_skip_en_o), .fixed_freq_o(fixed_freq_o),
      .load_balance_en_o(load_balance_en_o), .sink_a_current_adj_o(sink_a_current_adj_o),
      .sink_b_current_adj_o(sink_b_current_adj_o));
   // Free-running core clock, 25 ns period
   always #12.5 clk_i = ~clk_i;
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      tests_run++;
      if (seen !== exp)
      begin
         bad_count++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic test_done();
      $display("checks=%0d mismatches=%0d", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   // Inputs always move 2 ns after the rising edge so sampling never races
   task automatic cyc(input int n);
      repeat (n) @(posedge clk_i);
      #2;
   endtask
   // Queue a note; the monitor samples the selected output at the next edge
   task automatic expect_out(input logic [3:0] sel, input logic [15:0] exp);
      q.push_back({sel, exp});
      cyc(1);
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      reg_wr_i = 1;
      reg_addr_i = a;
      reg_wdata_i = d;
      cyc(1);
      reg_wr_i = 0;
      reg_addr_i = 8'h09;
   endtask
   // Counts cycles with the sink driven, cleared by the driver
   always @(posedge clk_i)
      hi_count <= clr ? 16'h0000 : hi_count + {15'h0000, sink_drive_o};
   // Monitor: takes the oldest note whenever a result is presented
   always @(posedge clk_i)
   begin
      logic [19:0] n;
      logic [15:0] s;
      cycles++;
      if (cycles == 40000)
      begin
         bad_count++;
         test_done();
      end
      else if (q.size() > 0)
      begin
         n = q.pop_front();
         case (n[19:16])
            4'h0: s = {8'h00, reg_rdata_o};
            4'h1: s = {14'h0000, pulse_skip_en_o, fixed_freq_o};
            4'h2: s = {15'h0000, load_balance_en_o};
            4'h3: s = {sink_a_current_adj_o, sink_b_current_adj_o};
            default: s = hi_count;
         endcase
         check(s, n[15:0]);
      end
   end
   initial
   begin
      logic [7:0] a, b;
      logic [1:0] md;
      logic fs, bo;
      void'($urandom(32'h6AD9A719));
      // Reset stands for 8 edges: 6 here and 2 more while its values are checked
      cyc(6);
      expect_out(4'h0, 16'h0000);
      expect_out(4'h1, 16'h0002);
      rst_n_i = 1;
      wr(8'h09, 8'hFF);
      expect_out(4'h0, 16'h0027);
      expect_out(4'h2, 16'h0001);
      wr(8'h0A, 8'h00);
      expect_out(4'h0, 16'h0027);
      reg_addr_i = 8'h0A;
      expect_out(4'h0, 16'h0000);
      reg_addr_i = 8'h09;
      // Mid-run reset must clear the fields written with all ones above
      rst_n_i = 0;
      cyc(1);
      expect_out(4'h0, 16'h0000);
      expect_out(4'h2, 16'h0000);
      rst_n_i = 1;
      for (int i = 0; i < 40; i++)
      begin
         md = 2'($urandom);
         a = 8'($urandom);
         b = 8'($urandom);
         fs = 1'($urandom);
         bo = 1'($urandom);
         // First passes pin the 40h threshold in both converter modes
         if (i < 4)
         begin
            md = {1'b1, i[0]};
            fs = 1'b1;
            bo = 1'b0;
            a = 8'h40;
            b = i[1] ? 8'h3F : 8'h40;
         end
         wr(8'h09, {5'h00, fs, 2'h0});
         mode_setting_i = md;
         sink_a_current_setting_i = a;
         sink_b_current_setting_i = b;
         current_boost_i = bo;
         cyc(1);
         fs = fs & md[1] & (a >= `LPIC_FIXED_MIN_CURRENT) & (b >= `LPIC_FIXED_MIN_CURRENT) & !bo;
         expect_out(4'h1, {14'h0000, !fs, fs});
      end
      // Flags and balance trim: 80h setting gives a trim of 0Ch
      {mode_setting_i, current_boost_i} = 3'h6;
      sink_a_current_setting_i = 8'h80;
      sink_b_current_setting_i = 8'h80;
      {converter_on_i, sink_a_above_cmp_i, sink_b_above_cmp_i} = 3'h6;
      wr(8'h09, 8'h20);
      cyc(5);
      expect_out(4'h0, 16'h0028);
      expect_out(4'h3, 16'h8C74);
      {converter_on_i, sink_a_above_cmp_i, sink_b_above_cmp_i} = 3'h1;
      cyc(5);
      expect_out(4'h0, 16'h0028);
      converter_on_i = 1;
      cyc(5);
      expect_out(4'h0, 16'h0030);
      expect_out(4'h3, 16'h748C);
      wr(8'h09, 8'h08);
      cyc(1);
      expect_out(4'h0, 16'h0010);
      expect_out(4'h3, 16'h8080);
      // Sink PWM: one full period of 16 slots of 79 cycles per duty code, then one period in flash mode with the sink always driven
      for (int d = 0; d < 5; d++)
      begin
         mode_setting_i = (d == 4) ? 2'h3 : 2'h0;
         wr(8'h09, 8'(d & 3));
         cyc(1264);
         clr = 1;
         cyc(1);
         clr = 0;
         cyc(1264);
         expect_out(4'h4, (d == 4) ? 16'h04F0 : 16'(`LPIC_SLOT_CYC * (d + 1)));
      end
      test_done();
   end
endmodule
